// >>> verilog/supervisor_cfg.svh
/*
 Offsets, reset values and timing counts of the supervisor block.
 Assumes a 50 MHz core clock and an APB bus with byte addresses.
*/
`ifndef SUPERVISOR_CFG_SVH
`define SUPERVISOR_CFG_SVH

`define OFS_KEY 8'h00
`define OFS_RELOAD 8'h04
`define OFS_POWER_CTL 8'h08
`define OFS_BUS_TIMING 8'h0c
`define OFS_WD_STATUS 8'h10

`define KEY_DISABLE 8'h55
`define BUS_TIMING_RST 8'heb
`define RESET_VECTOR 16'h0000
`define WD_ALL_ONES 24'hffffff
`define BASE_MC_PERIODS 3'd4

`define CLK_PERIOD_NS 20
`define SPIKE_FILTER_NS 100
`define SPIKE_FILTER_CYC ((`SPIKE_FILTER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ACTIVE_RESET_NS 10000000
`define ACTIVE_RESET_CYC (`ACTIVE_RESET_NS / `CLK_PERIOD_NS)

`endif

// >>> verilog/supervisor_pkg.sv
/*
 Types shared by the supervisor block: register layouts.
 Assumes supervisor_cfg.svh holds all numeric constants.
*/
package supervisor_pkg;

    typedef struct packed {
        logic pfq_en;
        logic bc_en;
        logic [1:0] write_wait;
        logic [1:0] read_wait;
        logic [1:0] code_wait;
    } bus_timing_t;

    typedef struct packed {
        logic power_down;
        logic idle;
        logic power_up;
    } power_ctl_t;

    typedef struct packed {
        logic enabled;
        logic [23:0] count;
    } wd_state_t;

endpackage

// >>> verilog/supervisor_reset_watchdog.sv
/*
 Reset supervisor: merges pin, undervoltage, debug and watchdog resets
 into one core reset, with APB-reached control registers.
 Assumes all inputs are synchronous to sys_clk except the pin and the
 undervoltage level, which are resynchronised here.
*/
// Local design decisions: the address map and the APB interface to the registers.

`include "supervisor_cfg.svh"

module supervisor_reset_watchdog #(
    parameter int ACTIVE_RESET_CYCLES = `ACTIVE_RESET_CYC
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic reset_in_n,
    input wire logic undervoltage_detect,
    input wire logic debug_reset_req,
    input wire logic mem_read_xfer,
    input wire logic mem_write_xfer,
    input wire logic fetch_stall,
    output logic core_reset,
    output logic logic_memory_reset_n,
    output logic core_restart,
    output logic [15:0] restart_addr,
    output logic idle_mode,
    output logic power_down_mode
);

    localparam int FILT_CYC = `SPIKE_FILTER_CYC;

    function automatic logic [2:0] bus_periods(input logic [1:0] code);
        bus_periods = `BASE_MC_PERIODS + {1'b0, code};
    endfunction

    // APB slave state
    logic pready_r, pready_nxt;
    logic pslverr_r, pslverr_nxt;
    logic [31:0] prdata_r, prdata_nxt;
    logic done, wr_key, wr_reload, wr_pctl, wr_bus;

    // Reset source state
    logic pin_s1_r, pin_s2_r, uv_s1_r, uv_s2_r;
    logic [7:0] filt_r, filt_nxt;
    logic [19:0] hold_r, hold_nxt;
    logic dbg_r, ext_req, uv_req;
    logic core_reset_r, core_reset_nxt;
    logic lm_reset_n_r, restart_r, restart_nxt;
    logic [15:0] restart_addr_r;

    // Control registers and watchdog
    logic [7:0] key_r, key_nxt;
    supervisor_pkg::bus_timing_t bus_r, bus_nxt;
    supervisor_pkg::power_ctl_t pctl_r, pctl_nxt;
    logic [23:0] cnt_r, cnt_nxt;
    logic wd_ovf_r, wd_ovf_nxt, wd_en;
    logic [2:0] phase_r, phase_nxt, mc_len;
    logic mc_end;
    supervisor_pkg::wd_state_t wd_stat;

    // Writes take effect only on the completing access edge
    assign done = psel & penable & pready_r;
    assign wr_key = done & pwrite & (paddr == `OFS_KEY);
    assign wr_reload = done & pwrite & (paddr == `OFS_RELOAD);
    assign wr_pctl = done & pwrite & (paddr == `OFS_POWER_CTL);
    assign wr_bus = done & pwrite & (paddr == `OFS_BUS_TIMING);

    assign wd_en = (key_r != `KEY_DISABLE) & ~pctl_r.idle & ~pctl_r.power_down;
    assign wd_stat = '{enabled: wd_en, count: cnt_r};

    always_comb begin
        pready_nxt = 1'b0;
        pslverr_nxt = 1'b0;
        prdata_nxt = prdata_r;
        if (reset_n && psel && penable && !pready_r) begin
            pready_nxt = 1'b1;
            prdata_nxt = 32'h0000_0000;
            if (paddr == `OFS_POWER_CTL) begin
                prdata_nxt = {29'h0, pctl_r};
            end else if (paddr == `OFS_BUS_TIMING) begin
                prdata_nxt = {24'h0, bus_r};
            end else if (paddr == `OFS_WD_STATUS) begin
                prdata_nxt = {7'h0, wd_stat};
            end else if (paddr != `OFS_KEY && paddr != `OFS_RELOAD) begin
                pslverr_nxt = 1'b1;
            end
        end
    end

    // pin must stay low for the filter count
    // release follows the pin with no stretch
    always_comb begin
        filt_nxt = filt_r;
        if (!reset_n || pin_s2_r) begin
            filt_nxt = 8'h00;
        end else if (filt_r != 8'(FILT_CYC)) begin
            filt_nxt = filt_r + 8'h01;
        end
    end
    assign ext_req = (filt_r == 8'(FILT_CYC));

    // hold the interval after supply recovers
    // no enable term can mask this source
    always_comb begin
        hold_nxt = hold_r;
        if (!reset_n) begin
            hold_nxt = 20'h00000;
        end else if (uv_s2_r) begin
            hold_nxt = 20'(ACTIVE_RESET_CYCLES);
        end else if (hold_r != 20'h00000) begin
            hold_nxt = hold_r - 20'h00001;
        end
    end
    assign uv_req = uv_s2_r | (hold_r != 20'h00000);

    // debug request is not gated by power modes
    // pin and overflow arrive already registered
    always_comb begin
        core_reset_nxt = 1'b1;
        restart_nxt = 1'b0;
        if (reset_n) begin
            core_reset_nxt = ext_req | uv_req | dbg_r | wd_ovf_r;
            restart_nxt = core_reset_r & ~core_reset_nxt;
        end
    end

    // transfers use the longer bus timing
    // wait codes give 4 to 7 clocks
    always_comb begin
        mc_len = `BASE_MC_PERIODS;
        if (mem_read_xfer && bus_periods(bus_r.read_wait) > mc_len) begin
            mc_len = bus_periods(bus_r.read_wait);
        end
        if (mem_write_xfer && bus_periods(bus_r.write_wait) > mc_len) begin
            mc_len = bus_periods(bus_r.write_wait);
        end
    end
    assign mc_end = ~core_reset_r & ~fetch_stall & (phase_r >= mc_len - 3'd1);

    always_comb begin
        phase_nxt = phase_r + 3'd1;
        if (!reset_n || core_reset_r || mc_end) begin
            phase_nxt = 3'd0;
        end else if (fetch_stall && phase_r >= mc_len - 3'd1) begin
            phase_nxt = phase_r;
        end
    end

    always_comb begin
        key_nxt = key_r;
        cnt_nxt = cnt_r;
        wd_ovf_nxt = 1'b0;
        bus_nxt = bus_r;
        pctl_nxt = pctl_r;
        if (!reset_n || core_reset_r) begin
            key_nxt = `KEY_DISABLE;
            cnt_nxt = 24'h000000;
            bus_nxt = `BUS_TIMING_RST;
            pctl_nxt.idle = 1'b0;
            pctl_nxt.power_down = 1'b0;
            if (!reset_n) begin
                pctl_nxt.power_up = 1'b1;
            end
        end else begin
            if (wr_key) begin
                key_nxt = pwdata[7:0];
            end
            if (wr_bus) begin
                bus_nxt = pwdata[7:0];
            end
            if (wr_pctl) begin
                pctl_nxt.idle = pwdata[1];
                pctl_nxt.power_down = pwdata[2];
                // Software may only clear the flag
                pctl_nxt.power_up = pctl_r.power_up & pwdata[0];
            end
            if (wr_reload) begin
                // top byte loaded, low bytes cleared
                cnt_nxt = {pwdata[7:0], 16'h0000};
            end else if (wd_en && mc_end) begin
                cnt_nxt = cnt_r + 24'h000001;
                if (cnt_r == `WD_ALL_ONES) begin
                    wd_ovf_nxt = 1'b1;
                    key_nxt = `KEY_DISABLE;
                end
            end
        end
        // a detected undervoltage beats a clear
        if (uv_s2_r) begin
            pctl_nxt.power_up = 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        pready_r <= pready_nxt;
        pslverr_r <= pslverr_nxt;
        prdata_r <= prdata_nxt;
        pin_s1_r <= reset_in_n;
        pin_s2_r <= pin_s1_r;
        uv_s1_r <= undervoltage_detect;
        uv_s2_r <= uv_s1_r;
        filt_r <= filt_nxt;
        hold_r <= hold_nxt;
        dbg_r <= reset_n & debug_reset_req;
        core_reset_r <= core_reset_nxt;
        // module reset follows core reset, inverted
        lm_reset_n_r <= ~core_reset_nxt;
        restart_r <= restart_nxt;
        restart_addr_r <= `RESET_VECTOR;
        key_r <= key_nxt;
        cnt_r <= cnt_nxt;
        wd_ovf_r <= wd_ovf_nxt;
        bus_r <= bus_nxt;
        pctl_r <= pctl_nxt;
        phase_r <= phase_nxt;
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign core_reset = core_reset_r;
    assign logic_memory_reset_n = lm_reset_n_r;
    assign core_restart = restart_r;
    assign restart_addr = restart_addr_r;
    assign idle_mode = pctl_r.idle;
    assign power_down_mode = pctl_r.power_down;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    a_merge_sources: assert property (
        (ext_req | uv_req | dbg_r | wd_ovf_r) |=> core_reset_r)
        else $error("reset source did not assert core reset");
    a_restart_edge: assert property (
        $fell(core_reset_r) |-> restart_r && restart_addr_r == `RESET_VECTOR)
        else $error("restart pulse missing at reset release");
    a_module_reset: assert property (
        lm_reset_n_r == ~core_reset_r)
        else $error("module reset not tracking core reset");
    a_pin_release: assert property (
        $past(pin_s2_r) && pin_s2_r && !uv_req && !dbg_r && !wd_ovf_r ##1 1 |-> !core_reset_r)
        else $error("pin reset stretched after release");
    a_uv_hold: assert property (
        $fell(uv_s2_r) |-> hold_r == 20'(ACTIVE_RESET_CYCLES) ##1 core_reset_r)
        else $error("undervoltage release not delayed");
    a_power_flag: assert property (
        uv_s2_r |=> pctl_r.power_up)
        else $error("power-up flag not set");
    a_debug_reset: assert property (
        debug_reset_req && pctl_r.idle |=> ##1 core_reset_r)
        else $error("debug reset ignored in idle");
    a_frozen_count: assert property (
        (pctl_r.idle || pctl_r.power_down) && !wr_reload && !core_reset_r |=> $stable(cnt_r))
        else $error("watchdog counted in low-power mode");
    a_key_reset: assert property (
        core_reset_r |=> key_r == `KEY_DISABLE && cnt_r == 24'h000000)
        else $error("reset did not relock watchdog");
    a_overflow: assert property (
        wd_ovf_r |-> key_r == `KEY_DISABLE && cnt_r == 24'h000000 ##1 core_reset_r)
        else $error("overflow did not reset and relock");
    a_reload_load: assert property (
        wr_reload && !core_reset_r |=> cnt_r == {$past(pwdata[7:0]), 16'h0000})
        else $error("reload did not load counter");
    a_mc_spacing: assert property (
        mc_end |=> !mc_end [*3])
        else $error("machine cycle shorter than four clocks");

endmodule

// >>> sim/reset_pin_source.sv
/*
 External reset source beside the supervisor: pulls the pin low for a requested number of clocks.
 Assumes start is a one-cycle request, driven just after a rising edge of sys_clk.
*/
module reset_pin_source (
    input wire logic sys_clk,
    input wire logic start,
    input wire logic [7:0] hold_cycles,
    output logic reset_in_n
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] left_r;

    // The pin has an internal pull-up, so it idles high between pulses
    initial begin
        reset_in_n = 1'b1;
        left_r = 8'h00;
    end

    // pin held low for the whole requested span
    always @(posedge sys_clk) begin
        if (start) begin
            left_r <= hold_cycles;
            reset_in_n <= 1'b0;
        end else if (left_r > 8'h01) begin
            left_r <= left_r - 8'h01;
        end else begin
            left_r <= 8'h00;
            reset_in_n <= 1'b1;
        end
    end
endmodule

// >>> sim/supervisor_reset_watchdog_test.sv
/*
 Self-checking bench of the reset supervisor and watchdog, driven over APB.
 Assumes the active reset interval is shortened to 20 cycles; fetch stalls only where a scenario raises them.
*/
`include "supervisor_cfg.svh"
module supervisor_reset_watchdog_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0, pslverr, pready;
    logic [7:0] paddr = 8'h00, hold = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic pin_n, start = 0, uv = 0, dbg = 0, rd_x = 0, wr_x = 0, stall = 0, e, restart_seen = 0;
    logic core_reset, lm_reset_n, core_restart, idle_mode, power_down_mode;
    logic [15:0] restart_addr;
    int errors = 0, samples_checked = 0, cyc = 0, n;

    supervisor_reset_watchdog #(.ACTIVE_RESET_CYCLES(20)) supervisor_reset_watchdog_i (.sys_clk(sys_clk),
        .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .reset_in_n(pin_n), .undervoltage_detect(uv),
        .debug_reset_req(dbg), .mem_read_xfer(rd_x), .mem_write_xfer(wr_x), .fetch_stall(stall),
        .core_reset(core_reset), .logic_memory_reset_n(lm_reset_n), .core_restart(core_restart),
        .restart_addr(restart_addr), .idle_mode(idle_mode), .power_down_mode(power_down_mode));
    reset_pin_source reset_pin_source_i (.sys_clk(sys_clk), .start(start), .hold_cycles(hold), .reset_in_n(pin_n));

    initial begin
        forever #10 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (core_restart === 1'b1) restart_seen <= 1'b1;
    end

    task check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task final_report;
        $display("errors=%0d samples_checked=%0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd, output logic er);
        int k;
        begin
            @(posedge sys_clk);
            {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
            @(posedge sys_clk);
            penable <= 1'b1;
            k = 0;
            do begin
                @(posedge sys_clk);
                k++;
            end while (pready !== 1'b1 && k < 50);
            if (k >= 50) check(0, 1);
            rd = prdata;
            er = pslverr;
            {psel, penable} <= 2'b00;
        end
    endtask

    task wait_low(input int lim);
        n = 0;
        while (core_reset !== 1'b0 && n < lim) begin
            @(posedge sys_clk);
            n++;
        end
    endtask

    // Count steps over a measured gap must match one step per machine cycle of div clocks
    task rate(input int div);
        logic [31:0] a, b;
        int c1, gap, d;
        begin
            apb(0, `OFS_WD_STATUS, 0, a, e);
            c1 = cyc;
            repeat (200) @(posedge sys_clk);
            apb(0, `OFS_WD_STATUS, 0, b, e);
            gap = cyc - c1;
            d = b[23:0] - a[23:0];
            check(a[24], 1);
            check(32'(d >= gap / div - 1 && d <= gap / div + 1), 1);
        end
    endtask

    task regs_after_reset;
        wait_low(40);
        repeat (2) @(posedge sys_clk);
        check(core_reset, 0);
        check(restart_seen, 1);
        check(restart_addr, 16'h0000);
        apb(0, `OFS_POWER_CTL, 0, r, e);
        check(r[0], 1);
        apb(0, `OFS_BUS_TIMING, 0, r, e);
        check(r[7:0], `BUS_TIMING_RST);
        apb(0, 8'h40, 0, r, e);
        check(e, 1);
        check(r, 0);
        apb(1, `OFS_POWER_CTL, 0, r, e);
        apb(0, `OFS_POWER_CTL, 0, r, e);
        check(r[0], 0);
        apb(0, `OFS_WD_STATUS, 0, r, e);
        check(r[24:0], 25'h0);
    endtask

    task watchdog_count;
        logic [31:0] a;
        apb(1, `OFS_KEY, 32'haa, r, e);
        apb(1, `OFS_RELOAD, 32'h12, r, e);
        apb(0, `OFS_WD_STATUS, 0, r, e);
        check(r[23:8], 16'h1200);
        rate(4);
        // A held stall parks the phase, so no machine cycle ends
        stall <= 1'b1;
        apb(0, `OFS_WD_STATUS, 0, a, e);
        repeat (20) @(posedge sys_clk);
        apb(0, `OFS_WD_STATUS, 0, r, e);
        check(r, a);
        stall <= 1'b0;
        rd_x <= 1'b1;
        for (int c = 0; c < 4; c++) begin
            apb(1, `OFS_BUS_TIMING, 32'(c << 2), r, e);
            rate(4 + c);
        end
        rd_x <= 1'b0;
        wr_x <= 1'b1;
        apb(1, `OFS_BUS_TIMING, 32'h30, r, e);
        rate(7);
        wr_x <= 1'b0;
        // Low bytes have grown well past 0002h by now, so a missing clear shows
        apb(1, `OFS_RELOAD, 32'h34, r, e);
        apb(0, `OFS_WD_STATUS, 0, r, e);
        check(32'(r[23:0] >= 24'h340000 && r[23:0] <= 24'h340002), 1);
    endtask

    task idle_then_debug;
        logic [31:0] a;
        begin
            // Idle first, then power-down alone
            for (int m = 0; m < 2; m++) begin
                apb(1, `OFS_POWER_CTL, 32'(2 << m), r, e);
                @(posedge sys_clk);
                check({power_down_mode, idle_mode}, 32'(1 << m));
                apb(0, `OFS_WD_STATUS, 0, a, e);
                repeat (20) @(posedge sys_clk);
                apb(0, `OFS_WD_STATUS, 0, r, e);
                check(r, a);
            end
            dbg <= 1'b1;
            repeat (5) @(posedge sys_clk);
            check(core_reset, 1);
            dbg <= 1'b0;
            wait_low(20);
            check({power_down_mode, idle_mode}, 0);
            apb(0, `OFS_WD_STATUS, 0, r, e);
            check(r[24:0], 25'h0);
        end
    endtask

    task pin_and_undervoltage;
        {start, hold} <= {1'b1, 8'd3};
        @(posedge sys_clk);
        start <= 1'b0;
        n = 0;
        repeat (15) begin
            @(posedge sys_clk);
            if (core_reset !== 1'b0) n++;
        end
        check(n, 0);
        {start, hold} <= {1'b1, 8'd30};
        @(posedge sys_clk);
        start <= 1'b0;
        repeat (15) @(posedge sys_clk);
        check({core_reset, lm_reset_n}, 2'b10);
        while (pin_n !== 1'b1) @(posedge sys_clk);
        wait_low(30);
        check(32'(n <= 5), 1);
        apb(0, `OFS_POWER_CTL, 0, r, e);
        check(r[0], 0);
        uv <= 1'b1;
        repeat (10) @(posedge sys_clk);
        uv <= 1'b0;
        repeat (15) @(posedge sys_clk);
        check(core_reset, 1);
        wait_low(30);
        check(32'(n >= 5 && n <= 12), 1);
        apb(0, `OFS_POWER_CTL, 0, r, e);
        check(r[0], 1);
    endtask

    initial begin
        repeat (20000) @(posedge sys_clk);
        errors++;
        final_report();
    end

    initial begin
        repeat (10) @(posedge sys_clk);
        reset_n <= 1'b1;
        regs_after_reset();
        watchdog_count();
        idle_then_debug();
        pin_and_undervoltage();
        final_report();
    end
endmodule
